/* rtl/csb_consts.svh */
// Offsets, field positions, reset values and timing counts of the core register bank
`ifndef CSB_CONSTS_SVH
`define CSB_CONSTS_SVH
`define CSB_OFS_INDIRECT 5'h00
`define CSB_OFS_TIMER0 5'h01
`define CSB_OFS_PC_LOW 5'h02
`define CSB_OFS_STATUS 5'h03
`define CSB_OFS_POINTER 5'h04
`define CSB_OFS_PORT 5'h05
`define CSB_OFS_PCLATCH 5'h0a
`define CSB_OFS_INTCTL 5'h0b
`define CSB_OFS_PIFLAGS 5'h0c
`define CSB_OFS_INT_STAT 5'h0d
`define CSB_OFS_INT_MASK 5'h0e
`define CSB_OFS_RESULT 5'h1e
`define CSB_OFS_CONVCTL 5'h1f
`define CSB_BIT_BANK 5
`define CSB_BIT_TIMEOUT 4
`define CSB_BIT_POWERDOWN 3
`define CSB_BIT_DONE 6
`define CSB_STATUS_MASK 8'h3f
`define CSB_PCLATCH_MASK 8'h1f
`define CSB_PIFLAGS_MASK 8'h40
`define CSB_CONVCTL_MASK 8'hdf
`define CSB_INTS_MASK 8'h07
`define CSB_RST_ZERO 8'h00
`define CSB_RST_STATUS_POR 8'h18
`define CSB_RST_PORT_HI 8'hc0
`define CSB_RST_STATUS_KEEP 8'h07
`define CSB_RST_INTCTL_KEEP 8'h01
`define CSB_QUARTERS 2'h3
`define CSB_Q_READ 2'h1
`define CSB_Q_WRITE 2'h3
`endif

/* rtl/csb_core_sfr_bank_zero.sv */
// Bank 0 core special function registers with a plain register port
// Overview of operation
// - Unimplemented addresses and bits read zero and ignore writes.
// - PC low, status, pointer, PC latch, interrupt control shared by both banks.
// - No file address reaches the program counter high byte directly.
// - Five-bit PC latch is copied into PC bits 12:8 on counter load.
// - Power-on reset differs from pin and watchdog resets in reset values.
// - Status, port, interrupt control, converter control take their table reset values.
// - Registers are static and hold contents whether or not the clock runs.
// - Status bit 5 selects bank 1 when set, bank 0 when clear.
// - Operand reads happen in quarter two, destination writes in quarter four.
//
// The strobed register port was left to the implementer.
`timescale 1ns/10ps
`include "csb_consts.svh"
module csb_core_sfr_bank_zero (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic por_n_i,
	input wire logic ext_reset_n_i,
	input wire logic wdt_reset_i,
	input wire logic [6:0] addr_i,
	input wire logic bank_mirror_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic [7:0] pc_low_i,
	input wire logic pc_load_i,
	output logic [4:0] pc_high_load_o,
	output logic pc_low_write_o,
	output logic [7:0] pc_low_data_o,
	input wire logic [7:0] indirect_data_i,
	output logic indirect_write_o,
	output logic [7:0] indirect_addr_o,
	output logic [7:0] indirect_wdata_o,
	input wire logic [7:0] timer0_i,
	output logic timer0_write_o,
	input wire logic [7:0] port_pins_i,
	output logic [7:0] port_latch_o,
	input wire logic [2:0] status_flags_i,
	input wire logic status_flags_load_i,
	input wire logic timeout_event_i,
	input wire logic powerdown_event_i,
	input wire logic [2:0] int_flag_set_i,
	input wire logic conversion_done_i,
	input wire logic [7:0] converter_result_i,
	output logic bank_select_o,
	output logic [7:0] interrupt_control_o,
	output logic [7:0] converter_control_o,
	output logic read_phase_o,
	output logic write_phase_o,
	output logic irq_o
);
	typedef struct packed {
		csb_pkg::csb_reset_kind_t reset_kind;
		logic reset_seen;
		logic [7:0] status;
		logic [7:0] pointer;
		logic [7:0] pclatch;
		logic [7:0] intctl;
		logic [7:0] piflags;
		logic [7:0] convctl;
		logic [7:0] port;
		logic [7:0] int_stat;
		logic [7:0] int_mask;
		logic [7:0] rdata;
		logic [4:0] pc_high;
	} csb_state_t;
	csb_state_t state;
	csb_state_t next_state;
	logic [7:0] port_sync;
	logic [7:0] result_sync;
	logic [4:0] addr_lo;
	logic in_bank0;
	logic mirrored;
	logic sel_ok;
	logic do_write;
	logic do_read;
	logic [7:0] events;

	csb_sync u_port_sync (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.d_i(port_pins_i),
		.q_o(port_sync)
	);
	// Converter result comes from the analog macro, so it is treated as foreign
	csb_sync u_result_sync (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.d_i(converter_result_i),
		.q_o(result_sync)
	);
	csb_quarter u_quarter (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.read_phase_o(read_phase_o),
		.write_phase_o(write_phase_o)
	);

	function automatic logic is_mirrored(input logic [4:0] a);
		is_mirrored = (a == `CSB_OFS_PC_LOW) || (a == `CSB_OFS_STATUS) ||
			(a == `CSB_OFS_POINTER) || (a == `CSB_OFS_PCLATCH) ||
			(a == `CSB_OFS_INTCTL) || (a == `CSB_OFS_INDIRECT);
	endfunction

	function automatic logic [7:0] reg_update(input logic [7:0] old, input logic [7:0] wv,
		input logic [7:0] mask);
		reg_update = (old & ~mask) | (wv & mask);
	endfunction

	assign addr_lo = addr_i[4:0];
	// Upper block of the bank holds general RAM, outside this register file
	assign in_bank0 = (addr_i[6:5] == 2'h0);
	assign mirrored = is_mirrored(addr_lo);
	// Bank 1 view only reaches the shared registers unless bank_mirror_i is set
	assign sel_ok = in_bank0 && (!state.status[`CSB_BIT_BANK] || mirrored || bank_mirror_i);
	assign do_write = wr_i && sel_ok;
	assign do_read = rd_i && sel_ok;
	assign events = {5'h00, conversion_done_i, timeout_event_i, powerdown_event_i};

	always_comb begin
		next_state = state;
		next_state.reset_seen = 1'b1;
		// Reset class decides which column of reset values applies
		if (!state.reset_seen) begin
			if (!por_n_i) begin
				next_state.reset_kind = csb_pkg::CSB_RST_POWER_ON;
			end else if (!ext_reset_n_i || wdt_reset_i) begin
				next_state.reset_kind = csb_pkg::CSB_RST_OTHER;
			end else begin
				next_state.reset_kind = csb_pkg::CSB_RST_POWER_ON;
			end
			if (next_state.reset_kind == csb_pkg::CSB_RST_POWER_ON) begin
				next_state.status = `CSB_RST_STATUS_POR;
				next_state.intctl = `CSB_RST_ZERO;
			end else begin
				next_state.status = {3'h0, wdt_reset_i, 1'b0, 3'h0} |
					(state.status & `CSB_RST_STATUS_KEEP);
				next_state.intctl = state.intctl & `CSB_RST_INTCTL_KEEP;
			end
			next_state.port = `CSB_RST_PORT_HI | (state.port & ~`CSB_RST_PORT_HI);
			next_state.convctl = `CSB_RST_ZERO;
			next_state.pclatch = `CSB_RST_ZERO;
			next_state.piflags = `CSB_RST_ZERO;
		end else begin
			if (status_flags_load_i) begin
				next_state.status[2:0] = status_flags_i;
			end
			if (timeout_event_i) begin
				next_state.status[`CSB_BIT_TIMEOUT] = 1'b0;
			end
			if (powerdown_event_i) begin
				next_state.status[`CSB_BIT_POWERDOWN] = 1'b0;
			end
			if (do_write) begin
				unique case (addr_lo)
					`CSB_OFS_STATUS: begin
						// Timeout and powerdown flags are read-only to software
						next_state.status = reg_update(next_state.status, wdata_i,
							`CSB_STATUS_MASK & 8'h27);
					end
					`CSB_OFS_POINTER: next_state.pointer = wdata_i;
					`CSB_OFS_PCLATCH: next_state.pclatch = reg_update(state.pclatch, wdata_i,
						`CSB_PCLATCH_MASK);
					`CSB_OFS_INTCTL: next_state.intctl = wdata_i;
					`CSB_OFS_PIFLAGS: next_state.piflags = reg_update(state.piflags, wdata_i,
						`CSB_PIFLAGS_MASK);
					`CSB_OFS_CONVCTL: next_state.convctl = reg_update(state.convctl, wdata_i,
						`CSB_CONVCTL_MASK);
					`CSB_OFS_PORT: next_state.port = wdata_i;
					`CSB_OFS_INT_MASK: next_state.int_mask = wdata_i & `CSB_INTS_MASK;
					`CSB_OFS_INT_STAT: next_state.int_stat = state.int_stat & ~wdata_i;
					default: next_state.pointer = next_state.pointer;
				endcase
			end
			// Hardware sets win over a same-cycle clear
			if (int_flag_set_i[0]) begin
				next_state.intctl[0] = 1'b1;
			end
			if (int_flag_set_i[1]) begin
				next_state.intctl[1] = 1'b1;
			end
			if (int_flag_set_i[2]) begin
				next_state.intctl[2] = 1'b1;
			end
			if (conversion_done_i) begin
				next_state.piflags[`CSB_BIT_DONE] = 1'b1;
				next_state.convctl[2] = 1'b0;
			end
			next_state.int_stat = (next_state.int_stat | events) & `CSB_INTS_MASK;
			if (pc_load_i) begin
				next_state.pc_high = state.pclatch[4:0];
			end
		end
		next_state.rdata = `CSB_RST_ZERO;
		if (do_read) begin
			unique case (addr_lo)
				`CSB_OFS_INDIRECT: next_state.rdata = indirect_data_i;
				`CSB_OFS_TIMER0: next_state.rdata = timer0_i;
				`CSB_OFS_PC_LOW: next_state.rdata = pc_low_i;
				`CSB_OFS_STATUS: next_state.rdata = state.status;
				`CSB_OFS_POINTER: next_state.rdata = state.pointer;
				`CSB_OFS_PORT: next_state.rdata = {state.port[7:6], port_sync[5:0]};
				`CSB_OFS_PCLATCH: next_state.rdata = state.pclatch & `CSB_PCLATCH_MASK;
				`CSB_OFS_INTCTL: next_state.rdata = state.intctl;
				`CSB_OFS_PIFLAGS: next_state.rdata = state.piflags & `CSB_PIFLAGS_MASK;
				`CSB_OFS_INT_STAT: next_state.rdata = state.int_stat;
				`CSB_OFS_INT_MASK: next_state.rdata = state.int_mask;
				`CSB_OFS_RESULT: next_state.rdata = result_sync;
				`CSB_OFS_CONVCTL: next_state.rdata = state.convctl & `CSB_CONVCTL_MASK;
				default: next_state.rdata = `CSB_RST_ZERO;
			endcase
		end
	end

	// Flops hold their value with no refresh; a stopped clock loses nothing
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state.reset_kind <= csb_pkg::CSB_RST_NONE;
			state.reset_seen <= 1'b0;
			state.rdata <= '0;
			state.pc_high <= '0;
			state.int_stat <= '0;
			state.int_mask <= '0;
		end else begin
			state <= next_state;
		end
	end

	// No read path exposes pc_high: it only leaves toward the program counter
	assign pc_high_load_o = state.pc_high;
	assign rdata_o = state.rdata;
	assign pc_low_write_o = do_write && (addr_lo == `CSB_OFS_PC_LOW);
	assign pc_low_data_o = wdata_i;
	assign indirect_write_o = do_write && (addr_lo == `CSB_OFS_INDIRECT);
	assign indirect_addr_o = state.pointer;
	assign indirect_wdata_o = wdata_i;
	assign timer0_write_o = do_write && (addr_lo == `CSB_OFS_TIMER0);
	assign port_latch_o = state.port;
	assign bank_select_o = state.status[`CSB_BIT_BANK];
	assign interrupt_control_o = state.intctl;
	assign converter_control_o = state.convctl;
	assign irq_o = |(state.int_stat & state.int_mask);
endmodule // csb_core_sfr_bank_zero

/* rtl/csb_pkg.sv */
// Types shared by the core register bank
package csb_pkg;
	typedef enum logic [1:0] {
		CSB_RST_NONE,
		CSB_RST_POWER_ON,
		CSB_RST_OTHER
	} csb_reset_kind_t;
endpackage

/* rtl/csb_quarter.sv */
// Quarter-cycle sequencer of the instruction cycle
`timescale 1ns/10ps
`include "csb_consts.svh"
module csb_quarter (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	output logic read_phase_o,
	output logic write_phase_o
);
	typedef struct packed {
		logic [1:0] quarter;
	} csb_quarter_state_t;
	csb_quarter_state_t state;
	csb_quarter_state_t next_state;
	always_comb begin
		next_state.quarter = (state.quarter == `CSB_QUARTERS) ? 2'h0 : state.quarter + 2'h1;
	end
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end
	assign read_phase_o = (state.quarter == `CSB_Q_READ);
	assign write_phase_o = (state.quarter == `CSB_Q_WRITE);
endmodule // csb_quarter

/* rtl/csb_sync.sv */
// Two-stage synchroniser for pin levels
`timescale 1ns/10ps
module csb_sync (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] d_i,
	output logic [7:0] q_o
);
	typedef struct packed {
		logic [7:0] first;
		logic [7:0] second;
	} csb_sync_state_t;
	csb_sync_state_t state;
	csb_sync_state_t next_state;
	always_comb begin
		next_state.first = d_i;
		next_state.second = state.first;
	end
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end
	assign q_o = state.second;
endmodule // csb_sync

/* verification/csb_chk.sv */
// Port-level assertions for the core register bank
`timescale 1ns/10ps
module csb_chk (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic [6:0] addr_i,
	input wire logic bank_mirror_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic pc_load_i,
	input wire logic [4:0] pc_high_load_o,
	input wire logic pc_low_write_o,
	input wire logic [7:0] pc_low_data_o,
	input wire logic indirect_write_o,
	input wire logic [7:0] indirect_addr_o,
	input wire logic [7:0] indirect_wdata_o,
	input wire logic write_phase_o,
	input wire logic timer0_write_o,
	input wire logic bank_select_o,
	input wire logic read_phase_o
);
	logic ok;
	assign ok = addr_i[6:5] == 2'h0 && (!bank_select_o || bank_mirror_i);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	idle_read_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data not zero");
	unmapped_zero_a: assert property (rd_i && addr_i[4:0] inside {[5'h06:5'h09],
		[5'h0f:5'h1d]} |=> rdata_o == 8'h00) else $error("hole read not zero");
	pc_low_write_a: assert property (wr_i && ok && addr_i[4:0] == 5'h02 |->
		pc_low_write_o && pc_low_data_o == wdata_i) else $error("pc low write lost");
	pointer_load_a: assert property (wr_i && ok && addr_i[4:0] == 5'h04 |=>
		indirect_addr_o == $past(wdata_i)) else $error("pointer not loaded");
	refused_write_a: assert property (wr_i && bank_select_o && !bank_mirror_i |->
		!(pc_low_write_o | indirect_write_o | timer0_write_o)) else $error("bank 1 leak");
	bank_bit_a: assert property (wr_i && ok && addr_i[4:0] == 5'h03 |=>
		bank_select_o == $past(wdata_i[5])) else $error("bank bit wrong");
	pch_hold_a: assert property (!pc_load_i |=> $stable(pc_high_load_o))
		else $error("pc high moved");
	quarter_a: assert property (read_phase_o |=> !read_phase_o [*3] ##1 read_phase_o)
		else $error("quarter period wrong");
	phase_order_a: assert property (read_phase_o |=> !write_phase_o ##1 write_phase_o)
		else $error("write phase misplaced");
	indirect_pass_a: assert property (indirect_write_o |-> indirect_wdata_o == wdata_i)
		else $error("indirect write data lost");
endmodule // csb_chk
bind csb_core_sfr_bank_zero csb_chk u_csb_chk (.*);

/* verification/csb_core_model.sv */
// Behavioural processor core holding the full program counter
`timescale 1ns/10ps
module csb_core_model (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic jump_i,
	input wire logic pc_low_write_i,
	input wire logic [7:0] pc_low_data_i,
	input wire logic [4:0] pc_high_i,
	output logic pc_load_o,
	output logic [12:0] pc_o
);
	logic load_q;
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pc_o <= '0;
			pc_load_o <= 1'b0;
			load_q <= 1'b0;
		end else begin
			// Only a jump or a low-byte write moves the high byte
			pc_load_o <= jump_i | pc_low_write_i;
			load_q <= pc_load_o;
			pc_o[7:0] <= pc_low_write_i ? pc_low_data_i : pc_o[7:0] + 8'h01;
			if (load_q)
				pc_o[12:8] <= pc_high_i;
		end
	end
endmodule // csb_core_model

/* verification/csb_core_sfr_bank_zero_tb.sv */
// Self-checking bench of the core register bank
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module csb_core_sfr_bank_zero_tb;
	logic ref_clk_i = 0, rst_n_i = 0, por_n_i = 0, ext_reset_n_i = 1, wdt_reset_i = 0;
	logic bank_mirror_i = 0, wr_i = 0, rd_i = 0, jump = 0, pc_load_i, status_flags_load_i;
	logic timeout_event_i, powerdown_event_i, conversion_done_i, pc_low_write_o;
	logic indirect_write_o, timer0_write_o, bank_select_o, read_phase_o, write_phase_o, irq_o;
	logic [2:0] status_flags_i = 0, int_flag_set_i;
	logic [4:0] pc_high_load_o;
	logic [6:0] addr_i = 0, evs = 0, ra [4] = '{7'h0a, 7'h0b, 7'h0c, 7'h1f};
	logic [7:0] wdata_i = 0, indirect_data_i = 0, timer0_i, port_pins_i, pc_low_i, v;
	logic [7:0] converter_result_i, rdata_o, pc_low_data_o, indirect_addr_o, indirect_wdata_o;
	logic [7:0] port_latch_o, interrupt_control_o, converter_control_o;
	logic [12:0] pc;
	int miscompares = 0, cmp_count = 0;
	assign {status_flags_load_i, timeout_event_i, powerdown_event_i, conversion_done_i,
		int_flag_set_i} = evs;
	assign pc_low_i = pc[7:0];
	csb_core_sfr_bank_zero u_csb_core_sfr_bank_zero (.*);
	csb_core_model u_csb_core_model (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .jump_i(jump),
		.pc_low_write_i(pc_low_write_o), .pc_low_data_i(pc_low_data_o),
		.pc_high_i(pc_high_load_o), .pc_load_o(pc_load_i), .pc_o(pc));
	initial forever #50 ref_clk_i = ~ref_clk_i;
	task automatic tk(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1 `CHK(rdata_o, e)
	endtask
	task automatic ev(input logic [6:0] m);
		@(posedge ref_clk_i) evs <= m;
		@(posedge ref_clk_i) evs <= 7'h00;
	endtask
	// Power-on wins by holding the pin and watchdog causes idle
	task automatic rst(input logic p, input logic w);
		@(posedge ref_clk_i);
		rst_n_i <= 1'b0;
		por_n_i <= p;
		ext_reset_n_i <= w | ~p;
		wdt_reset_i <= w & p;
		tk(2);
		rst_n_i <= 1'b1;
		tk(2);
		{por_n_i, ext_reset_n_i, wdt_reset_i} <= 3'h6;
	endtask
	task automatic end_of_test;
		$display("cmp_count=%0d miscompares=%0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		void'($urandom(79));
		port_pins_i = 8'($urandom);
		timer0_i = 8'($urandom);
		converter_result_i = 8'($urandom);
		rst(1'b0, 1'b0);
		rd(7'h03, 8'h18);
		foreach (ra[i]) rd(ra[i], 8'h00);
		rd(7'h05, {2'b11, port_pins_i[5:0]});
		$display("test 1 end");
		for (int a = 6; a < 30; a++) if (a < 10 || a > 14) begin
			wr(7'(a), 8'($urandom));
			rd(7'(a), 8'h00);
		end
		for (int i = 0; i < 8; i++) begin
			v = i ? 8'($urandom) : 8'hff;
			wr(7'h04, v);
			rd(7'h04, v);
			wr(7'h1f, v);
			rd(7'h1f, v & 8'hdf);
			wr(7'h0c, v);
			rd(7'h0c, v & 8'h40);
			wr(7'h0a, v);
			rd(7'h0a, v & 8'h1f);
			@(posedge ref_clk_i) jump <= 1'b1;
			@(posedge ref_clk_i) jump <= 1'b0;
			tk(3);
			`CHK(pc[12:8], v[4:0])
			`CHK(pc_high_load_o, v[4:0])
		end
		$display("test 2 end");
		wr(7'h03, 8'h20);
		#1 `CHK(bank_select_o, 1'b1)
		rd(7'h01, 8'h00);
		wr(7'h01, 8'h11);
		@(posedge ref_clk_i) bank_mirror_i <= 1'b1;
		rd(7'h03, 8'h38);
		wr(7'h03, 8'h00);
		@(posedge ref_clk_i) bank_mirror_i <= 1'b0;
		rd(7'h01, timer0_i);
		@(posedge ref_clk_i) status_flags_i <= 3'h5;
		ev(7'h7f);
		rd(7'h03, 8'h05);
		rd(7'h0d, 8'h07);
		rd(7'h0c, 8'h40);
		`CHK(irq_o, 1'b0)
		`CHK(converter_control_o, v & 8'hdb)
		wr(7'h0e, 8'h02);
		#1 `CHK(irq_o, 1'b1)
		wr(7'h0d, 8'h02);
		#1 `CHK(irq_o, 1'b0)
		wr(7'h1e, ~converter_result_i);
		rd(7'h1e, converter_result_i);
		wr(7'h0b, 8'hf8);
		ev(7'h01);
		#1 `CHK(interrupt_control_o, 8'hf9)
		wr(7'h02, 8'h40);
		#1 `CHK(pc[7:0], 8'h40)
		@(posedge ref_clk_i) indirect_data_i <= 8'h5a;
		rd(7'h00, 8'h5a);
		wr(7'h00, 8'h33);
		wr(7'h04, 8'h3c);
		$display("test 3 end");
		for (int w = 0; w < 2; w++) begin
			rst(1'b1, w[0]);
			rd(7'h03, {3'h0, w[0], 1'b0, 3'h5});
			rd(7'h0b, 8'h01);
			rd(7'h05, {2'b11, port_pins_i[5:0]});
			rd(7'h04, 8'h3c);
			`CHK(indirect_addr_o, 8'h3c)
			`CHK(port_latch_o[7:6], 2'b11)
		end
		$display("test 4 end");
		end_of_test;
	end
	initial begin
		tk(20000);
		miscompares++;
		end_of_test;
	end
endmodule // csb_core_sfr_bank_zero_tb
